// *** hdl/wtb_pkg.sv ***
// package: constants, register map and types of the watchdog/timebase block
// Function
// (RQ1) watchdog counts from option clock: watchdog osc, instruction clock, or rtc osc
// (RQ2) watchdog disabled by option makes every watchdog instruction a no-op
// (RQ3) watchdog times out after 2^15 to 2^16 source clock periods
// (RQ4) instruction-clock watchdog stops in halt; only external reset restarts
// (RQ5) overflow while running gives full chip reset and sets timeout flag
// (RQ6) overflow while halted gives warm reset: program counter and stack only
// (RQ7) watchdog cleared by reset pin, clear instructions, or halt
// (RQ8) option picks single clear or paired first-and-second clear scheme
// (RQ9) shared timer is 8-stage divider then 7-bit prescaler
// (RQ10) option taps: lcd fs/2^2..2^8, buzzer fs/2^2..2^9
// (RQ11) time base sets flag bit 5 at option period, vector 14H
// (RQ12) time-base and rtc time-outs offered as counter clock sources
// (RQ13) rtc select bits 2:0 at 09H map to 2^8..2^15
// (RQ14) rtc time-out sets flag bit 6, vector 18H when enabled
// (RQ15) halt stops system osc, clears watchdog, sets powerdown, clears timeout
// (RQ16) halt ends on reset, interrupt, port A fall, or watchdog overflow
// (RQ17) powerdown flag cleared at power-up or single clear, set by halt
// (RQ18) each port A pin option-enabled for wake; resumes next instruction
// (RQ19) interrupt wake calls only if enabled with stack room; old flags ignored
// (RQ20) every wake inserts 1024 system clock delay before resuming; a reset-pin exit from halt goes straight to run
// (RQ21) timeout/powerdown flags encode the reset cause
// (RQ22) chip reset clears timer chain, watchdog, rtc, time base, vector 000H
// (RQ23) quick-start bit 4 of rtc control drives the rtc oscillator boost
// (RQ24) request flags stay set until software clears or the call services them
`default_nettype none
package wtb_pkg;
  // ---------------------------------------------------------------------
  // register map (byte offsets on the plain port)
  // ---------------------------------------------------------------------
  localparam logic [7:0] WTB_RTC_CTRL_ADDR = 8'h09;
  localparam logic [7:0] WTB_SECOND_INTERRUPT_CONTROL_ADDR = 8'h1E;
  localparam logic [7:0] WTB_STATUS_ADDR = 8'h0A;
  localparam logic [7:0] WTB_RTC_CTRL_RST = 8'h07;
  localparam int WTB_QUICK_START_OSCILLATOR_BIT_BIT = 4;
  localparam int WTB_TBE_BIT = 1;
  localparam int WTB_RTE_BIT = 2;
  localparam int WTB_TBF_BIT = 5;
  localparam int WTB_RTF_BIT = 6;
  localparam int WTB_PDF_BIT = 4;
  localparam int WTB_TO_BIT = 5;
  // ---------------------------------------------------------------------
  // timing and vectors
  // ---------------------------------------------------------------------
  localparam int WTB_DIV_STAGES = 8;
  localparam int WTB_PRE_BITS = 7;
  localparam int WTB_WDT_BITS = 16;
  localparam int WTB_SST_CYCLES = 1024;
  localparam int WTB_TB_BASE = 12;
  localparam int WTB_RTC_BASE = 8;
  localparam logic [11:0] WTB_VEC_TB = 12'h014;
  localparam logic [11:0] WTB_VEC_RTC = 12'h018;
  localparam logic [11:0] WTB_VEC_RESET = 12'h000;
  // watchdog clock source option codes
  localparam logic [1:0] WTB_SRC_WDOSC = 2'h0;
  localparam logic [1:0] WTB_SRC_INSTR = 2'h1;
  localparam logic [1:0] WTB_SRC_RTC = 2'h2;

  typedef enum logic [1:0] {
    WTB_RUN,
    WTB_HALT,
    WTB_START,
    WTB_STUCK
  } wtb_mode_t;
endpackage : wtb_pkg
`default_nettype wire

// *** hdl/wtb_tick_if.sv ***
// interface: source tick and timer chain taps shared inside the block
`default_nettype none
interface wtb_tick_if;
  logic tick; // one-cycle source clock event
  logic clr; // clear the whole chain
  logic [14:0] chain; // divider + prescaler state
  logic [15:0] rise; // per-stage rising pulses, bit n = fs/2^(n+1)
  modport chain_m (input tick, input clr, output chain, output rise);
  modport user_m (output tick, output clr, input chain, input rise);
endinterface : wtb_tick_if
`default_nettype wire

// *** hdl/wtb_chain.sv ***
// module: shared divider and prescaler chain with per-stage edge pulses
`default_nettype none
module wtb_chain
  import wtb_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  wtb_tick_if.chain_m tk // tick in, taps out
);
  typedef struct packed {
    logic [WTB_DIV_STAGES+WTB_PRE_BITS-1:0] cnt;
    logic [15:0] rise;
  } wtb_chain_st_t;
  wtb_chain_st_t st, next_st;
  logic [WTB_DIV_STAGES+WTB_PRE_BITS-1:0] inc;

  // ---------------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------------
  // rise bit n pulses when stage n goes 0->1, i.e. at rate fs/2^(n+1)
  always_comb begin
    next_st = st;
    inc = st.cnt + 1'b1;
    next_st.rise = '0;
    if (tk.clr) begin
      next_st.cnt = '0; // [RQ22]
    end else if (tk.tick) begin
      next_st.cnt = inc; // [RQ9]
      next_st.rise = {1'b0, inc & ~st.cnt};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign tk.chain = st.cnt;
  assign tk.rise = st.rise;
endmodule : wtb_chain
`default_nettype wire

// *** hdl/wtb_top.sv ***
// module: watchdog, time base, rtc, halt and reset-cause logic
//
// Design decision made here: the strobed register port.
`default_nettype none
module wtb_top
  import wtb_pkg::*;
#(
  parameter int PA_W = 8, // port A width
  parameter int SST_CYCLES = WTB_SST_CYCLES // wake start-up delay
) (
  input wire logic ref_clk, // 25 MHz system clock
  input wire logic reset_n, // async power-up reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic wdosc_clk, // watchdog rc oscillator pin
  input wire logic rtcosc_clk, // rtc oscillator pin
  input wire logic ext_reset_n, // external_reset_pin, active low
  input wire logic [PA_W-1:0] port_a, // port A pins
  input wire logic [PA_W-1:0] opt_wake_en, // per-pin wake option
  input wire logic opt_wdt_en, // watchdog enable option
  input wire logic [1:0] opt_wdt_src, // watchdog clock source option
  input wire logic opt_clr_paired, // paired clear scheme option
  input wire logic [2:0] opt_lcd_sel, // lcd tap 0..6 -> fs/2^2..2^8
  input wire logic [2:0] opt_buz_sel, // buzzer tap 0..7 -> fs/2^2..2^9
  input wire logic [1:0] opt_tb_sel, // time base 0..3 -> fs/2^12..2^15
  input wire logic instr_tick, // one pulse per instruction cycle
  input wire logic cmd_clr_single, // single_watchdog_clear executed
  input wire logic cmd_clr_first, // paired_clear_first executed
  input wire logic cmd_clr_second, // paired_clear_second executed
  input wire logic cmd_halt, // halt instruction executed
  input wire logic other_irq, // other interrupt requests rising
  input wire logic stack_full, // cpu stack full
  input wire logic int_master_en, // cpu master interrupt enable
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic chip_reset, // full chip reset pulse
  output logic warm_reset, // pc and stack pointer reset pulse
  output logic sys_osc_en, // system oscillator enable
  output logic cpu_run, // cpu may execute
  output logic int_call, // vectored call pulse
  output logic [11:0] int_vector, // call target address
  output logic lcd_clk, // lcd frequency tap
  output logic buz_clk, // buzzer frequency tap
  output logic tb_tick, // time-base timeout pulse for counter 1
  output logic rtc_tick, // rtc timeout pulse for counter 0
  output logic rtc_quick_osc // quick_start_oscillator_bit drive
);
  localparam int SW = $clog2(SST_CYCLES + 1);

  typedef struct packed {
    logic [2:0] wd_s; // watchdog osc synchroniser
    logic [2:0] rt_s; // rtc osc synchroniser
    logic [2:0] rs_s; // reset pin synchroniser
    logic [3*PA_W-1:0] pa_s; // port A synchronisers, 3 per pin
    logic [WTB_WDT_BITS-1:0] wdt;
    logic paired_first; // first of the pair seen
    logic to_flag; // timeout_status_flag
    logic pd_flag; // powerdown_status_flag
    logic timebase_request_flag; // timebase_request_flag
    logic clock_tick_request_flag; // clock_tick_request_flag
    logic tbe; // time base interrupt enable
    logic rte; // rtc interrupt enable
    logic tbf_pre; // flag already set when halt began
    logic rtf_pre;
    logic [7:0] rtc_ctrl; // rtc_period_control
    wtb_mode_t mode;
    logic [SW-1:0] startup_delay_timer; // startup_delay_timer
    logic wake_call; // wake will take the vectored call
    logic chip_rst;
    logic warm_rst;
    logic call;
    logic [11:0] vec;
    logic [7:0] rdata;
    logic lcd;
    logic buz;
  } wtb_st_t;
  wtb_st_t st, next_st;
  wtb_tick_if tk ();
  logic src_tick, wd_edge, rt_edge, rs_low, wd_clr, tb_ev, rt_ev;
  logic pa_fall_any, irq_wake, wdt_ovf, halted;
  logic [PA_W-1:0] pa_fall;

  wtb_chain u_chain (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tk(tk)
  );

  // ---------------------------------------------------------------------
  // pin conditioning: three flops, rising edge counts when stage 2 high and stage 3 low, reset pin low when both low
  // ---------------------------------------------------------------------
  assign wd_edge = st.wd_s[1] & ~st.wd_s[2] & ~st.wd_s[2];
  assign rt_edge = st.rt_s[1] & ~st.rt_s[2];
  assign rs_low = ~st.rs_s[1] & ~st.rs_s[2];
  genvar g;
  generate
    for (g = 0; g < PA_W; g++) begin : g_pa
      // falling edge on an option-enabled pin
      assign pa_fall[g] = opt_wake_en[g] & ~st.pa_s[3*g+1]
                          & st.pa_s[3*g+2]; // [RQ18]
    end
  endgenerate
  assign pa_fall_any = |pa_fall;
  assign halted = (st.mode == WTB_HALT);

  // ---------------------------------------------------------------------
  // source tick and chain taps
  // ---------------------------------------------------------------------
  // instruction clock stops in halt, so that source freezes there
  always_comb begin
    if (opt_wdt_src == WTB_SRC_WDOSC) begin
      src_tick = wd_edge; // [RQ1]
    end else if (opt_wdt_src == WTB_SRC_INSTR) begin
      src_tick = instr_tick & (st.mode == WTB_RUN); // [RQ1] [RQ4]
    end else begin
      src_tick = rt_edge; // [RQ1]
    end
  end
  assign tk.tick = src_tick;
  assign tk.clr = st.chip_rst; // [RQ22]
  assign tb_ev = tk.rise[WTB_TB_BASE - 1 + opt_tb_sel]; // [RQ11]
  assign rt_ev = tk.rise[WTB_RTC_BASE - 1 + st.rtc_ctrl[2:0]]; // [RQ13]
  assign wdt_ovf = opt_wdt_en & src_tick & (&st.wdt); // [RQ3]

  // watchdog clears; all watchdog instructions are no-ops when disabled
  assign wd_clr = opt_wdt_en & ((cmd_halt & ~halted)
    | (~opt_clr_paired & cmd_clr_single)
    | (opt_clr_paired & ((st.paired_first & cmd_clr_second)
    | (cmd_clr_first & cmd_clr_second)))); // [RQ2] [RQ7] [RQ8]

  // wake by interrupt only for flags newly raised during halt
  assign irq_wake = other_irq | (st.timebase_request_flag & ~st.tbf_pre)
    | (st.clock_tick_request_flag & ~st.rtf_pre); // [RQ19]

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wd_s = {st.wd_s[1:0], wdosc_clk};
    next_st.rt_s = {st.rt_s[1:0], rtcosc_clk};
    next_st.rs_s = {st.rs_s[1:0], ext_reset_n};
    for (int i = 0; i < PA_W; i++) begin
      next_st.pa_s[3*i +: 3] = {st.pa_s[3*i +: 2], port_a[i]};
    end
    next_st.chip_rst = 1'b0;
    next_st.warm_rst = 1'b0;
    next_st.call = 1'b0;
    next_st.rdata = '0;
    next_st.lcd = tk.chain[1 + opt_lcd_sel]; // [RQ10]
    next_st.buz = tk.chain[1 + opt_buz_sel]; // [RQ10]
    // watchdog counter
    if (opt_wdt_en && src_tick) begin
      next_st.wdt = st.wdt + 1'b1; // [RQ3]
    end
    if (cmd_clr_first && opt_clr_paired && opt_wdt_en) begin
      next_st.paired_first = 1'b1; // [RQ8]
    end
    if (wd_clr) begin
      next_st.wdt = '0; // [RQ7]
      next_st.paired_first = 1'b0;
    end
    if (cmd_clr_single && opt_wdt_en && !opt_clr_paired) begin
      next_st.pd_flag = 1'b0; // [RQ17]
      next_st.to_flag = 1'b0;
    end
    // software register writes (clear before hardware set: set wins)
    if (reg_wr) begin
      if (reg_addr == WTB_RTC_CTRL_ADDR) begin
        next_st.rtc_ctrl = {3'h0, reg_wdata[4:0]}; // [RQ13] [RQ23]
      end else if (reg_addr == WTB_SECOND_INTERRUPT_CONTROL_ADDR) begin
        next_st.tbe = reg_wdata[WTB_TBE_BIT];
        next_st.rte = reg_wdata[WTB_RTE_BIT];
        next_st.timebase_request_flag = reg_wdata[WTB_TBF_BIT]; // [RQ24]
        next_st.clock_tick_request_flag = reg_wdata[WTB_RTF_BIT]; // [RQ24]
      end
    end
    if (reg_rd) begin
      if (reg_addr == WTB_RTC_CTRL_ADDR) begin
        next_st.rdata = st.rtc_ctrl;
      end else if (reg_addr == WTB_SECOND_INTERRUPT_CONTROL_ADDR) begin
        next_st.rdata = 8'h00;
        next_st.rdata[WTB_TBE_BIT] = st.tbe;
        next_st.rdata[WTB_RTE_BIT] = st.rte;
        next_st.rdata[WTB_TBF_BIT] = st.timebase_request_flag;
        next_st.rdata[WTB_RTF_BIT] = st.clock_tick_request_flag;
      end else if (reg_addr == WTB_STATUS_ADDR) begin
        next_st.rdata = 8'h00;
        next_st.rdata[WTB_TO_BIT] = st.to_flag; // [RQ21]
        next_st.rdata[WTB_PDF_BIT] = st.pd_flag;
      end
    end
    // interrupt service while running: the call clears its own flag
    if (st.mode == WTB_RUN && int_master_en && !stack_full) begin
      if (st.timebase_request_flag && st.tbe) begin
        next_st.call = 1'b1;
        next_st.vec = WTB_VEC_TB; // [RQ11]
        next_st.timebase_request_flag = 1'b0; // [RQ24]
      end else if (st.clock_tick_request_flag && st.rte) begin
        next_st.call = 1'b1;
        next_st.vec = WTB_VEC_RTC; // [RQ14]
        next_st.clock_tick_request_flag = 1'b0; // [RQ24]
      end
    end
    if (tb_ev) begin
      next_st.timebase_request_flag = 1'b1; // [RQ11]
    end
    if (rt_ev) begin
      next_st.clock_tick_request_flag = 1'b1; // [RQ14]
    end
    // mode sequencing
    case (st.mode)
      WTB_RUN: begin
        if (wdt_ovf) begin
          next_st.chip_rst = 1'b1; // [RQ5]
          next_st.to_flag = 1'b1; // [RQ5] [RQ21]
          next_st.wdt = '0;
          // a chip reset also drops time base, rtc and their enables
          next_st.timebase_request_flag = 1'b0; // [RQ22]
          next_st.clock_tick_request_flag = 1'b0;
          next_st.tbe = 1'b0;
          next_st.rte = 1'b0;
          next_st.rtc_ctrl = WTB_RTC_CTRL_RST;
          next_st.paired_first = 1'b0;
        end else if (cmd_halt) begin
          next_st.mode = (opt_wdt_src == WTB_SRC_INSTR && opt_wdt_en)
            ? WTB_STUCK : WTB_HALT; // [RQ4]
          next_st.pd_flag = 1'b1; // [RQ15] [RQ17]
          next_st.to_flag = 1'b0; // [RQ15]
          next_st.tbf_pre = st.timebase_request_flag; // [RQ19]
          next_st.rtf_pre = st.clock_tick_request_flag;
        end
      end
      WTB_HALT: begin
        if (wdt_ovf) begin
          next_st.warm_rst = 1'b1; // [RQ6]
          next_st.to_flag = 1'b1; // [RQ21]
          next_st.wdt = '0;
          next_st.wake_call = 1'b0;
          next_st.mode = WTB_START; // [RQ16]
          next_st.startup_delay_timer = '0;
        end else if (pa_fall_any || irq_wake) begin
          next_st.wake_call = int_master_en & ~stack_full & ~pa_fall_any
            & ((st.timebase_request_flag & st.tbe) | (st.clock_tick_request_flag & st.rte)); // [RQ19]
          next_st.mode = WTB_START; // [RQ16] [RQ18]
          next_st.startup_delay_timer = '0;
        end
      end
      WTB_START: begin
        next_st.startup_delay_timer = st.startup_delay_timer + 1'b1;
        if (st.startup_delay_timer == SW'(SST_CYCLES - 1)) begin
          next_st.mode = WTB_RUN; // [RQ20]
        end
      end
      default: begin
        // only the reset pin leaves this state
      end
    endcase
    // external reset pin: full init, cause flags per halt state
    if (rs_low) begin
      next_st.wdt = '0; // [RQ7]
      next_st.chip_rst = 1'b1; // [RQ16] [RQ22]
      next_st.mode = WTB_RUN;
      next_st.timebase_request_flag = 1'b0;
      next_st.clock_tick_request_flag = 1'b0;
      next_st.tbe = 1'b0;
      next_st.rte = 1'b0;
      next_st.rtc_ctrl = WTB_RTC_CTRL_RST;
      next_st.paired_first = 1'b0;
      if (st.mode != WTB_RUN) begin
        next_st.to_flag = 1'b0; // [RQ21]
        next_st.pd_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.rs_s <= 3'h7;
      st.rtc_ctrl <= WTB_RTC_CTRL_RST; // [RQ22]
      st.mode <= WTB_RUN;
      st.vec <= WTB_VEC_RESET; // [RQ22]
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign chip_reset = st.chip_rst;
  assign warm_reset = st.warm_rst;
  assign sys_osc_en = (st.mode == WTB_RUN) || (st.mode == WTB_START); // [RQ15]
  assign cpu_run = (st.mode == WTB_RUN);
  assign int_call = st.call;
  assign int_vector = st.vec;
  assign lcd_clk = st.lcd;
  assign buz_clk = st.buz;
  assign tb_tick = tb_ev; // [RQ12]
  assign rtc_tick = rt_ev; // [RQ12]
  assign rtc_quick_osc = st.rtc_ctrl[WTB_QUICK_START_OSCILLATOR_BIT_BIT]; // [RQ23]

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  wdt_overflow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && wdt_ovf && st.mode == WTB_RUN && !rs_low |=> chip_reset
    && st.to_flag) else $error("run overflow without reset"); // [RQ5]
  warm_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && wdt_ovf && halted && !rs_low |=> warm_reset && !chip_reset)
    else $error("halt overflow without warm reset"); // [RQ6]
  halt_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && cmd_halt && st.mode == WTB_RUN && !wdt_ovf && !rs_low
    |=> st.pd_flag && !st.to_flag && st.wdt == '0)
    else $error("halt entry flags wrong"); // [RQ15]
  wdt_disabled_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && !opt_wdt_en && !rs_low
    |=> $stable(st.wdt) && !chip_reset && !warm_reset)
    else $error("watchdog acts while disabled"); // [RQ2]
  paired_clr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    opt_clr_paired && cmd_clr_single && !cmd_halt |-> !wd_clr)
    else $error("single clear acted in paired mode"); // [RQ8]
  tb_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && tb_ev && !rs_low && !(wdt_ovf && cpu_run) |=> st.timebase_request_flag)
    else $error("time base flag not set"); // [RQ11]
  rtc_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && rt_ev && !rs_low && !(wdt_ovf && cpu_run) |=> st.clock_tick_request_flag)
    else $error("rtc flag not set"); // [RQ14]
  chip_init_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && wdt_ovf && cpu_run && !rs_low
    |=> st.rtc_ctrl == WTB_RTC_CTRL_RST && !st.tbe && !st.rte)
    else $error("chip reset left rtc or time base"); // [RQ22]
  sst_delay_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && halted && $past(clk_en) ##1 st.mode == WTB_START
    |-> !cpu_run[*8]) else $error("wake resumed too early"); // [RQ20]
  rtc_tap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rtc_tick |-> tk.chain[WTB_RTC_BASE - 1 + st.rtc_ctrl[2:0]]
    && !tk.chain[WTB_RTC_BASE - 2 + st.rtc_ctrl[2:0]])
    else $error("rtc tap mismatch"); // [RQ13]
endmodule : wtb_top
`default_nettype wire

// *** dv/wtb_cpu_model.sv ***
// cpu partner model: instruction clock, master enable and stack depth
`default_nettype none
module wtb_cpu_model (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // power-up reset, active low
  input wire logic cpu_run, // execution allowed
  input wire logic int_call, // vectored call pulse
  input wire logic warm_reset, // pc and stack pointer reset
  input wire logic ie_on, // software wants interrupts
  output logic instr_tick, // instruction clock pulse
  output logic int_master_en, // master enable seen by the block
  output logic stack_full // no room for another call
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] depth;
  logic [3:0] svc;
  // one tick a cycle keeps the long watchdog count short; none in halt
  assign instr_tick = cpu_run & reset_n;
  assign stack_full = (depth == 5'h10);
  // the call masks further calls until a short service returns
  assign int_master_en = ie_on & (svc == 4'h0);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      depth <= 5'h00;
      svc <= 4'h0;
    end else if (warm_reset) begin
      depth <= 5'h00;
      svc <= 4'h0;
    end else if (int_call) begin
      depth <= depth + 5'h01;
      svc <= 4'h8;
    end else if (svc != 4'h0) begin
      svc <= svc - 4'h1;
      if (svc == 4'h1) depth <= depth - 5'h01;
    end
  end
endmodule // wtb_cpu_model
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench: register port, taps, interrupts, halt, reset cause, watchdog
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wtb_pkg::*;
  logic ref_clk, reset_n, wdosc_clk, rtcosc_clk, ext_reset_n, ie_on;
  logic reg_wr, reg_rd, chip_reset, warm_reset, sys_osc_en, cpu_run;
  logic int_call, lcd_clk, buz_clk, tb_tick, rtc_tick, rtc_quick_osc;
  logic instr_tick, stack_full, int_master_en;
  logic opt_wdt_en, opt_clr_paired;
  logic [3:0] cmd_v;
  logic [7:0] port_a, opt_wake_en, reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0] opt_wdt_src, opt_tb_sel;
  logic [2:0] opt_lcd_sel, opt_buz_sel;
  logic [11:0] int_vector;
  int n_mismatch, cmp_count, n;
  wtb_top #(.PA_W(8), .SST_CYCLES(16)) i_wtb_top (.ref_clk, .reset_n,
    .clk_en(1'b1), .wdosc_clk, .rtcosc_clk, .ext_reset_n, .port_a,
    .opt_wake_en, .opt_wdt_en, .opt_wdt_src, .opt_clr_paired,
    .opt_lcd_sel, .opt_buz_sel, .opt_tb_sel, .instr_tick,
    .cmd_clr_single(cmd_v[0]), .cmd_clr_first(cmd_v[1]),
    .cmd_clr_second(cmd_v[2]), .cmd_halt(cmd_v[3]), .other_irq(1'b0),
    .stack_full, .int_master_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .chip_reset, .warm_reset, .sys_osc_en, .cpu_run, .int_call,
    .int_vector, .lcd_clk, .buz_clk, .tb_tick, .rtc_tick, .rtc_quick_osc);
  wtb_cpu_model i_wtb_cpu_model (.ref_clk, .reset_n, .cpu_run, .int_call,
    .warm_reset, .ie_on, .instr_tick, .int_master_en, .stack_full);
  // 40 ns system clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // both slow oscillators tick every second cycle so long counts stay short
  always @(posedge ref_clk) begin
    wdosc_clk <= ~wdosc_clk;
    rtcosc_clk <= wdosc_clk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, dt);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [7:0] a, exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  task automatic cmd(input int k);
    @(posedge ref_clk);
    cmd_v[k] <= 1'b1;
    @(posedge ref_clk);
    cmd_v <= 4'h0;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return cpu_run;
      1: return int_call;
      2: return chip_reset;
      3: return rtc_tick;
      4: return lcd_clk;
      default: return buz_clk;
    endcase
  endfunction
  task automatic waitfor(input int w, input logic v, input int lim,
                         output int c);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (sig(w) !== v && c < lim);
    if (c >= lim) begin
      n_mismatch++;
      $display("BAD wait %0d expected %b seen %b", w, v, ~v);
      stop_test();
    end
  endtask
  // cycles between two rising edges of one output
  task automatic gap(input int w, output int c);
    int a;
    waitfor(w, 1'b0, 20000, a);
    waitfor(w, 1'b1, 20000, a);
    waitfor(w, 1'b0, 20000, a);
    waitfor(w, 1'b1, 20000, c);
    c += a;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rdc("rtc_ctrl", WTB_RTC_CTRL_ADDR, WTB_RTC_CTRL_RST);
    rdc("status", WTB_STATUS_ADDR, 8'h00);
    rdc("second_interrupt_control", WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h00);
    rdc("unmapped", 8'h3F, 8'h00);
    wr(WTB_RTC_CTRL_ADDR, 8'h14);
    rdc("rtc_ctrl", WTB_RTC_CTRL_ADDR, 8'h14);
    chk("quick_osc", rtc_quick_osc, 1'b1);
  endtask
  task automatic t_taps();
    gap(4, n);
    chk("lcd_gap", n, 8);
    gap(5, n);
    chk("buz_gap", n, 1024);
    for (int c = 0; c < 3; c++) begin
      wr(WTB_RTC_CTRL_ADDR, 8'(c));
      gap(3, n);
      chk("rtc_gap", n, 512 << c);
    end
  endtask
  task automatic t_ints();
    // slowest time base keeps its flag out of the rtc reads
    opt_tb_sel <= 2'h3;
    wr(WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h04);
    ie_on <= 1'b1;
    waitfor(1, 1'b1, 3000, n);
    chk("rtc_vec", int_vector, WTB_VEC_RTC);
    rdc("rtc_flag_clr", WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h04);
    wr(WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h00);
    waitfor(3, 1'b1, 3000, n);
    rdc("rtc_flag_hold", WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h40);
    wr(WTB_RTC_CTRL_ADDR, 8'h07);
    opt_tb_sel <= 2'h0;
    wr(WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h02);
    waitfor(1, 1'b1, 9000, n);
    chk("tb_vec", int_vector, WTB_VEC_TB);
    wr(WTB_SECOND_INTERRUPT_CONTROL_ADDR, 8'h00);
    ie_on <= 1'b0;
    opt_tb_sel <= 2'h3;
  endtask
  task automatic t_halt();
    cmd(3);
    @(negedge ref_clk);
    chk("halt_run", {cpu_run, sys_osc_en}, 2'b00);
    rdc("halt_flags", WTB_STATUS_ADDR, 8'h10);
    port_a[1] <= 1'b0;
    repeat (40) @(negedge ref_clk);
    chk("masked_pin", cpu_run, 1'b0);
    port_a[0] <= 1'b0;
    waitfor(0, 1'b1, 100, n);
    chk("start_delay", n >= 16 && n <= 24, 1'b1);
    port_a <= 8'hFF;
    cmd(0);
    rdc("clr_flags", WTB_STATUS_ADDR, 8'h00);
  endtask
  task automatic t_stuck();
    opt_wdt_src <= WTB_SRC_INSTR;
    cmd(3);
    port_a[0] <= 1'b0;
    repeat (40) @(negedge ref_clk);
    chk("stuck", cpu_run, 1'b0);
    ext_reset_n <= 1'b0;
    waitfor(2, 1'b1, 50, n);
    ext_reset_n <= 1'b1;
    port_a <= 8'hFF;
    waitfor(0, 1'b1, 100, n);
    rdc("pin_halt_flags", WTB_STATUS_ADDR, 8'h10);
    rdc("rtc_ctrl_init", WTB_RTC_CTRL_ADDR, 8'h07);
  endtask
  task automatic t_wdt();
    opt_wdt_en <= 1'b0;
    cmd(0);
    rdc("off_clr", WTB_STATUS_ADDR, 8'h10);
    opt_wdt_en <= 1'b1;
    opt_clr_paired <= 1'b1;
    cmd(0);
    rdc("paired_single", WTB_STATUS_ADDR, 8'h10);
    wr(WTB_RTC_CTRL_ADDR, 8'h15);
    cmd(1);
    cmd(2);
    waitfor(2, 1'b1, 70000, n);
    chk("wdt_time", n >= 65530 && n <= 65545, 1'b1);
    rdc("wdt_flags", WTB_STATUS_ADDR, 8'h30);
    rdc("wdt_rtc_init", WTB_RTC_CTRL_ADDR, 8'h07);
  endtask
  // everything starts defined; reset is held for 16 cycles
  initial begin
    reset_n = 1'b0;
    ext_reset_n = 1'b1;
    wdosc_clk = 1'b0;
    rtcosc_clk = 1'b0;
    ie_on = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    cmd_v = 4'h0;
    port_a = 8'hFF;
    opt_wake_en = 8'h01;
    opt_wdt_en = 1'b1;
    opt_clr_paired = 1'b0;
    opt_wdt_src = WTB_SRC_WDOSC;
    opt_tb_sel = 2'h0;
    opt_lcd_sel = 3'h0;
    opt_buz_sel = 3'h7;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_taps();
    t_ints();
    t_halt();
    t_stuck();
    t_wdt();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
